// >>> logic/ocef_pkg.sv
// Package for the overcurrent and earth-fault trip logic
package ocef_pkg;
  localparam int CLK_HZ = 20_000_000;
  localparam int MS_CYC = CLK_HZ / 1000;
  localparam logic [4:0] OFS_CTRL     = 5'h00;
  localparam logic [4:0] OFS_PH_LOW   = 5'h04;
  localparam logic [4:0] OFS_PH_HIGH  = 5'h08;
  localparam logic [4:0] OFS_EF_LOW   = 5'h0C;
  localparam logic [4:0] OFS_EF_HIGH  = 5'h10;
  localparam logic [4:0] OFS_MATRIX   = 5'h14;
  localparam logic [4:0] OFS_STATUS   = 5'h18;
  localparam logic [4:0] OFS_TIMES    = 5'h1C;
  localparam logic [31:0] CTRL_RST    = 32'h0000_0007;
  localparam logic [31:0] MATRIX_RST  = 32'h0000_0000;
  localparam logic [31:0] THR_RST     = 32'h0000_FFFF;
  localparam logic [31:0] TIMES_RST   = 32'h0000_0000;
  localparam int CT_PHEN = 0;
  localparam int CT_INVERSE_TIME_CHARACTERISTIC = 3;
  localparam int CT_HINST = 4;
  localparam int CT_BLK = 5;
  localparam int CT_EXTTRIP = 9;
  localparam int CT_DPOLE = 10;
  localparam int CT_FAIL = 11;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// >>> logic/ocef_trip_logic.sv
// Overcurrent and earth-fault start, timing and trip logic with AXI4-Lite registers
//
// Implementation choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
// Functional notes
// R1: Phase above low-set starts stage and timer
// R2: Low-set overcurrent trips when timer elapses
// R3: High-set overcurrent starts, times, trips
// R4: Low-set choose definite or inverse time
// R5: High-set overcurrent instantaneous or definite
// R6: Evaluate three, two or one phases
// R7: Matrix routes starts to contact outputs
// R8: One external control input, channel eight
// R9: Control input blocks stages or trips
// R10: Earth-fault low-set starts on residual current
// R11: Earth-fault low-set trips when timer elapses
// R12: Earth-fault high-set starts, times, trips
// R13: Earth-fault stages definite time only
// R14: Control input can block earth-fault stages
// R15: All trips drive breaker open output
// R16: Single-pole default, double-pole optional
// R17: Trip circuit supervised by injected current
// R18: Five signal contacts, one internal fault
// R19: Four signals show stage start or trip
// R20: Drop below start resets stage silently
module ocef_trip_logic #(
  parameter int CW = 16,
  parameter int TW = 24
) (
  input  wire logic          CLK_SYS,       // System clock
  input  wire logic          RST,           // Sync reset, high
  input  wire logic [CW-1:0] I_PH_A,        // Phase A magnitude
  input  wire logic [CW-1:0] I_PH_B,        // Phase B magnitude
  input  wire logic [CW-1:0] I_PH_C,        // Phase C magnitude
  input  wire logic [CW-1:0] I_RES,         // Residual current
  input  wire logic          EXT_CTRL,      // External control input
  input  wire logic          TCS_OK,        // Trip circuit current seen
  input  wire logic          SELF_OK,       // Self-supervision healthy
  output logic               OPEN_P,        // Breaker open, positive pole
  output logic               OPEN_N,        // Breaker open, negative pole
  output logic               TCS_INJECT,    // Supervision current enable
  output logic [3:0]         SIGNAL,        // Signal contacts 1..4
  output logic               INTERNAL_FAULT_ALARM, // Internal fault contact
  input  wire logic [4:0]    S_AXI_AWADDR,  // AXI write address
  input  wire logic          S_AXI_AWVALID, // AXI
  output logic               S_AXI_AWREADY, // AXI
  input  wire logic [31:0]   S_AXI_WDATA,   // AXI
  input  wire logic [3:0]    S_AXI_WSTRB,   // AXI
  input  wire logic          S_AXI_WVALID,  // AXI
  output logic               S_AXI_WREADY,  // AXI
  output logic [1:0]         S_AXI_BRESP,   // AXI
  output logic               S_AXI_BVALID,  // AXI
  input  wire logic          S_AXI_BREADY,  // AXI
  input  wire logic [4:0]    S_AXI_ARADDR,  // AXI
  input  wire logic          S_AXI_ARVALID, // AXI
  output logic               S_AXI_ARREADY, // AXI
  output logic [31:0]        S_AXI_RDATA,   // AXI
  output logic [1:0]         S_AXI_RRESP,   // AXI
  output logic               S_AXI_RVALID,  // AXI
  input  wire logic          S_AXI_RREADY   // AXI
);
  // Stage indices: 0 phase low, 1 phase high, 2 earth low, 3 earth high
  logic [31:0] ctrl_reg, ph_low_reg, ph_high_reg, ef_low_reg, ef_high_reg;
  logic [31:0] matrix_reg, times_reg;
  logic [TW-1:0] tmr_reg [4];
  logic [15:0] pre_reg;
  logic [3:0]  start_reg, trip_reg;
  logic        tcs_fail_reg;
  logic        ms_tick;

  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] be);
    for (int i = 0; i < 4; i++)
      wmerge[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
  endfunction

  // Phase enable mask: bits 0..2
  wire [2:0] ph_en = ctrl_reg[ocef_pkg::CT_PHEN +: 3]; // R6
  wire [CW-1:0] ph_a = ph_en[0] ? I_PH_A : '0;
  wire [CW-1:0] ph_b = ph_en[1] ? I_PH_B : '0;
  wire [CW-1:0] ph_c = ph_en[2] ? I_PH_C : '0;
  wire [CW-1:0] ab_max = (ph_a > ph_b) ? ph_a : ph_b;
  wire [CW-1:0] ph_max = (ab_max > ph_c) ? ab_max : ph_c;
  wire [3:0] blk_sel = ctrl_reg[ocef_pkg::CT_BLK +: 4];
  wire [3:0] blocked = EXT_CTRL ? blk_sel : 4'h0; // R8 R9 R14
  wire ext_trip = EXT_CTRL && ctrl_reg[ocef_pkg::CT_EXTTRIP]; // R9
  wire [3:0] above;
  assign above[0] = ph_max > ph_low_reg[CW-1:0]; // R1
  assign above[1] = ph_max > ph_high_reg[CW-1:0]; // R3
  assign above[2] = I_RES > ef_low_reg[CW-1:0]; // R10
  assign above[3] = I_RES > ef_high_reg[CW-1:0]; // R12
  wire [3:0] started = above & ~blocked;
  // Inverse time: set time scaled by threshold over current
  wire [TW+CW-1:0] inverse_time_characteristic_num = (TW+CW)'(times_reg[7:0]);
  wire [TW+CW-1:0] inverse_time_characteristic_q = (inverse_time_characteristic_num * (TW+CW)'(ph_low_reg[CW-1:0]))
                            / (TW+CW)'(ph_max | {{(CW-1){1'b0}}, 1'b1});
  wire [TW-1:0] t_low_ph = ctrl_reg[ocef_pkg::CT_INVERSE_TIME_CHARACTERISTIC] ? inverse_time_characteristic_q[TW-1:0]
                                                       : TW'(times_reg[7:0]); // R4
  wire [TW-1:0] t_set [4];
  assign t_set[0] = t_low_ph;
  assign t_set[1] = ctrl_reg[ocef_pkg::CT_HINST] ? '0 : TW'(times_reg[15:8]); // R5
  assign t_set[2] = TW'(times_reg[23:16]); // R13
  assign t_set[3] = TW'(times_reg[31:24]); // R13
  assign ms_tick = (pre_reg == 16'(ocef_pkg::MS_CYC - 1));
  wire any_trip = (|trip_reg) || ext_trip; // R15

  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
      pre_reg <= 16'h0000;
    else
      pre_reg <= ms_tick ? 16'h0000 : pre_reg + 16'h0001;
  end

  // Each stage times in ms ticks while started; drop-out clears it
  for (genvar s = 0; s < 4; s++)
  begin : g_stage
    always_ff @(posedge CLK_SYS)
    begin
      if (RST || !started[s])
      begin
        tmr_reg[s]   <= '0; // R20
        start_reg[s] <= 1'b0;
        trip_reg[s]  <= 1'b0;
      end
      else
      begin
        start_reg[s] <= 1'b1; // R1 R3 R10 R12
        if (tmr_reg[s] >= t_set[s])
          trip_reg[s] <= 1'b1; // R2 R3 R11 R12
        else if (ms_tick)
          tmr_reg[s] <= tmr_reg[s] + TW'(1);
      end
    end
  end

  // Outputs and supervision
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      OPEN_P <= 1'b0;
      OPEN_N <= 1'b0;
      TCS_INJECT <= 1'b0;
      tcs_fail_reg <= 1'b0;
      SIGNAL <= 4'h0;
      INTERNAL_FAULT_ALARM <= 1'b0;
    end
    else
    begin
      OPEN_P <= any_trip; // R15 R16
      OPEN_N <= any_trip && ctrl_reg[ocef_pkg::CT_DPOLE]; // R16
      TCS_INJECT <= 1'b1; // R17
      tcs_fail_reg <= !any_trip && !TCS_OK; // R17
      for (int k = 0; k < 4; k++)
        SIGNAL[k] <= |((start_reg & matrix_reg[k*8 +: 4])
                      | (trip_reg & matrix_reg[k*8+4 +: 4])); // R7 R19
      INTERNAL_FAULT_ALARM <= !SELF_OK; // R18
    end
  end

  // AXI4-Lite slave: single-cycle accept, writes once both AW and W valid, reads once AR valid
  wire wr_go = S_AXI_AWVALID && S_AXI_WVALID && !S_AXI_BVALID;
  wire rd_go = S_AXI_ARVALID && !S_AXI_RVALID;
  wire [4:0] wa = S_AXI_AWADDR;
  wire wr_hit = (wa == ocef_pkg::OFS_CTRL) || (wa == ocef_pkg::OFS_PH_LOW)
             || (wa == ocef_pkg::OFS_PH_HIGH) || (wa == ocef_pkg::OFS_EF_LOW)
             || (wa == ocef_pkg::OFS_EF_HIGH) || (wa == ocef_pkg::OFS_MATRIX)
             || (wa == ocef_pkg::OFS_TIMES);
  wire [31:0] status_w = {18'h00000, tcs_fail_reg, OPEN_P, trip_reg, start_reg, 4'h0};
  logic [31:0] rd_mux;
  logic        rd_hit;
  always_comb
  begin
    rd_hit = 1'b1;
    case (S_AXI_ARADDR)
      ocef_pkg::OFS_CTRL:    rd_mux = ctrl_reg;
      ocef_pkg::OFS_PH_LOW:  rd_mux = ph_low_reg;
      ocef_pkg::OFS_PH_HIGH: rd_mux = ph_high_reg;
      ocef_pkg::OFS_EF_LOW:  rd_mux = ef_low_reg;
      ocef_pkg::OFS_EF_HIGH: rd_mux = ef_high_reg;
      ocef_pkg::OFS_MATRIX:  rd_mux = matrix_reg;
      ocef_pkg::OFS_STATUS:  rd_mux = status_w;
      ocef_pkg::OFS_TIMES:   rd_mux = times_reg;
      default:
      begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      ctrl_reg <= ocef_pkg::CTRL_RST;
      ph_low_reg <= ocef_pkg::THR_RST;
      ph_high_reg <= ocef_pkg::THR_RST;
      ef_low_reg <= ocef_pkg::THR_RST;
      ef_high_reg <= ocef_pkg::THR_RST;
      matrix_reg <= ocef_pkg::MATRIX_RST;
      times_reg <= ocef_pkg::TIMES_RST;
    end
    else if (wr_go)
    begin
      case (wa)
        ocef_pkg::OFS_CTRL:    ctrl_reg <= wmerge(ctrl_reg, S_AXI_WDATA, S_AXI_WSTRB);
        ocef_pkg::OFS_PH_LOW:  ph_low_reg <= wmerge(ph_low_reg, S_AXI_WDATA, S_AXI_WSTRB);
        ocef_pkg::OFS_PH_HIGH: ph_high_reg <= wmerge(ph_high_reg, S_AXI_WDATA, S_AXI_WSTRB);
        ocef_pkg::OFS_EF_LOW:  ef_low_reg <= wmerge(ef_low_reg, S_AXI_WDATA, S_AXI_WSTRB);
        ocef_pkg::OFS_EF_HIGH: ef_high_reg <= wmerge(ef_high_reg, S_AXI_WDATA, S_AXI_WSTRB);
        ocef_pkg::OFS_MATRIX:  matrix_reg <= wmerge(matrix_reg, S_AXI_WDATA, S_AXI_WSTRB);
        ocef_pkg::OFS_TIMES:   times_reg <= wmerge(times_reg, S_AXI_WDATA, S_AXI_WSTRB);
        default:               ctrl_reg <= ctrl_reg;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= ocef_pkg::RESP_OKAY;
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= ocef_pkg::RESP_OKAY;
    end
    else
    begin
      S_AXI_AWREADY <= wr_go;
      S_AXI_WREADY <= wr_go;
      if (wr_go)
      begin
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= wr_hit ? ocef_pkg::RESP_OKAY : ocef_pkg::RESP_SLVERR;
      end
      else if (S_AXI_BREADY)
        S_AXI_BVALID <= 1'b0;
      S_AXI_ARREADY <= rd_go;
      if (rd_go)
      begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA <= rd_mux;
        S_AXI_RRESP <= rd_hit ? ocef_pkg::RESP_OKAY : ocef_pkg::RESP_SLVERR;
      end
      else if (S_AXI_RREADY)
        S_AXI_RVALID <= 1'b0;
    end
  end
endmodule

// >>> verification/ocef_plant.sv
// Trip circuit supervision loop seen by the trip logic
`timescale 1ns/1ps
module ocef_plant (
  input  wire logic clk,    // Clock
  input  wire logic inject, // Supervision current on
  input  wire logic cut,    // Broken trip circuit
  output logic      tcs_ok  // Continuity seen
);
  initial tcs_ok = 1'b0;
  always @(posedge clk)
  begin
    tcs_ok <= inject && !cut;
  end
endmodule

// >>> verification/ocef_properties.sv
// Port-level checks for the trip logic
`timescale 1ns/1ps
module ocef_props (
  input wire logic       CLK_SYS,              // Clock
  input wire logic       RST,                  // Reset
  input wire logic       SELF_OK,              // Health
  input wire logic       INTERNAL_FAULT_ALARM, // Alarm
  input wire logic       OPEN_P,               // Open
  input wire logic       OPEN_N,               // Open
  input wire logic       S_AXI_AWVALID,        // AXI
  input wire logic       S_AXI_WVALID,         // AXI
  input wire logic       S_AXI_AWREADY,        // AXI
  input wire logic       S_AXI_WREADY,         // AXI
  input wire logic       S_AXI_BVALID,         // AXI
  input wire logic       S_AXI_BREADY,         // AXI
  input wire logic [1:0] S_AXI_BRESP,          // AXI
  input wire logic       S_AXI_ARVALID,        // AXI
  input wire logic       S_AXI_ARREADY,        // AXI
  input wire logic       S_AXI_RVALID,         // AXI
  input wire logic       S_AXI_RREADY          // AXI
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  a_alarm_set: assert property (!SELF_OK |=> INTERNAL_FAULT_ALARM)
    else $error("alarm missing");
  a_alarm_clear: assert property (SELF_OK |=> !INTERNAL_FAULT_ALARM)
    else $error("alarm stuck");
  a_second_pole: assert property (OPEN_N |-> OPEN_P)
    else $error("second pole alone");
  a_write_taken: assert property (S_AXI_AWVALID && S_AXI_WVALID && !S_AXI_BVALID
    |=> S_AXI_AWREADY && S_AXI_WREADY && S_AXI_BVALID) else $error("write not taken");
  a_ready_pulse: assert property (S_AXI_AWREADY |=> !S_AXI_AWREADY)
    else $error("awready long");
  a_read_taken: assert property (S_AXI_ARVALID && !S_AXI_RVALID
    |=> S_AXI_ARREADY && S_AXI_RVALID) else $error("read not taken");
  a_bresp_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY
    |=> S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("bvalid dropped");
  a_rvalid_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID)
    else $error("rvalid dropped");
  c_trip: cover property ($rose(OPEN_P));
  c_two_pole: cover property (OPEN_N);
  c_alarm: cover property (INTERNAL_FAULT_ALARM);
endmodule
bind ocef_trip_logic ocef_props chk_i (.*);

// >>> verification/ocef_trip_logic_tb.sv
// Self-checking bench for the overcurrent and earth-fault trip logic
`timescale 1ns/1ps
module ocef_trip_logic_tb;
  logic        CLK_SYS = 1'b0, RST = 1'b1, EXT_CTRL = 1'b0, SELF_OK = 1'b1, cut = 1'b0;
  logic [15:0] I_PH_A = 16'h0, I_PH_B = 16'h0, I_PH_C = 16'h0, I_RES = 16'h0;
  logic [4:0]  S_AXI_AWADDR = 5'h0, S_AXI_ARADDR = 5'h0;
  logic [31:0] S_AXI_WDATA = 32'h0, S_AXI_RDATA;
  logic [3:0]  S_AXI_WSTRB = 4'hF, SIGNAL;
  logic        S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0;
  logic        S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0;
  logic        TCS_OK, OPEN_P, OPEN_N, TCS_INJECT, INTERNAL_FAULT_ALARM;
  logic        S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
  logic [1:0]  S_AXI_BRESP, S_AXI_RRESP;
  int          fails = 0, samples_checked = 0, cyc = 0;
  ocef_trip_logic uut (.*);
  ocef_plant plant (.clk(CLK_SYS), .inject(TCS_INJECT), .cut(cut), .tcs_ok(TCS_OK));
  initial forever #25 CLK_SYS = ~CLK_SYS;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge CLK_SYS);
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d,
                    input logic [1:0] er = ocef_pkg::RESP_OKAY);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    do
    begin
      @(posedge CLK_SYS);
      if (S_AXI_AWREADY === 1'b1) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY === 1'b1) S_AXI_WVALID <= 1'b0;
      if (S_AXI_BVALID === 1'b1) S_AXI_BREADY <= 1'b1;
    end while (S_AXI_BREADY !== 1'b1 || S_AXI_BVALID !== 1'b1);
    S_AXI_BREADY <= 1'b0;
    chk({30'h0, S_AXI_BRESP}, {30'h0, er});
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] exp);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    do
    begin
      @(posedge CLK_SYS);
      if (S_AXI_ARREADY === 1'b1) S_AXI_ARVALID <= 1'b0;
      if (S_AXI_RVALID === 1'b1) S_AXI_RREADY <= 1'b1;
    end while (S_AXI_RREADY !== 1'b1 || S_AXI_RVALID !== 1'b1);
    S_AXI_RREADY <= 1'b0;
    chk(S_AXI_RDATA, exp);
  endtask
  task automatic t_regs;
    rd(ocef_pkg::OFS_CTRL, ocef_pkg::CTRL_RST);
    rd(ocef_pkg::OFS_PH_LOW, ocef_pkg::THR_RST);
    rd(ocef_pkg::OFS_TIMES, ocef_pkg::TIMES_RST);
    wr(ocef_pkg::OFS_STATUS, 32'h1, ocef_pkg::RESP_SLVERR);
    rd(ocef_pkg::OFS_STATUS, 32'h0);
    $display("t_regs done");
  endtask
  task automatic t_phase;
    wr(ocef_pkg::OFS_MATRIX, 32'h1001);
    wr(ocef_pkg::OFS_TIMES, 32'h1);
    wr(ocef_pkg::OFS_CTRL, 32'h2);
    wr(ocef_pkg::OFS_PH_LOW, 32'h64);
    I_PH_A <= 16'h00C8;
    wt(10);
    chk({27'h0, OPEN_P, SIGNAL}, 32'h0);
    I_PH_B <= 16'h00C8;
    wt(10);
    chk({27'h0, OPEN_P, SIGNAL}, 32'h1);
    I_PH_B <= 16'h0;
    wt(3);
    chk({27'h0, OPEN_P, SIGNAL}, 32'h0);
    I_PH_B <= 16'h00C8;
    wt(40010);
    chk({27'h0, OPEN_P, SIGNAL}, 32'h13);
    I_PH_A <= 16'h0;
    I_PH_B <= 16'h0;
    wr(ocef_pkg::OFS_PH_LOW, 32'hFFFF);
    $display("t_phase done");
  endtask
  task automatic t_stages;
    wr(ocef_pkg::OFS_TIMES, 32'h0);
    wr(ocef_pkg::OFS_CTRL, 32'h7);
    for (int s = 0; s < 4; s++)
    begin
      wr(5'(4 * s + 4), 32'h64);
      if (s < 2) I_PH_C <= 16'h00C8;
      else I_RES <= 16'h00C8;
      wt(5);
      rd(ocef_pkg::OFS_STATUS, 32'h1000 | (32'h110 << s));
      I_PH_C <= 16'h0;
      I_RES <= 16'h0;
      wr(5'(4 * s + 4), 32'hFFFF);
    end
    $display("t_stages done");
  endtask
  task automatic t_modes;
    wr(ocef_pkg::OFS_TIMES, 32'h0000_FF08);
    wr(ocef_pkg::OFS_CTRL, 32'hF);
    wr(ocef_pkg::OFS_PH_LOW, 32'h64);
    I_PH_A <= 16'h0320;
    wt(20010);
    chk({27'h0, OPEN_P, SIGNAL}, 32'h13);
    I_PH_A <= 16'h0;
    wr(ocef_pkg::OFS_PH_LOW, 32'hFFFF);
    wr(ocef_pkg::OFS_CTRL, 32'h17);
    wr(ocef_pkg::OFS_PH_HIGH, 32'h64);
    I_PH_A <= 16'h00C8;
    wt(5);
    rd(ocef_pkg::OFS_STATUS, 32'h1220);
    I_PH_A <= 16'h0;
    wr(ocef_pkg::OFS_PH_HIGH, 32'hFFFF);
    $display("t_modes done");
  endtask
  task automatic t_ext;
    wr(ocef_pkg::OFS_EF_LOW, 32'h32);
    wr(ocef_pkg::OFS_CTRL, 32'h580);
    EXT_CTRL <= 1'b1;
    I_RES <= 16'h0064;
    wt(5);
    chk({31'h0, OPEN_P}, 32'h0);
    EXT_CTRL <= 1'b0;
    wt(5);
    chk({30'h0, OPEN_P, OPEN_N}, 32'h3);
    I_RES <= 16'h0;
    wr(ocef_pkg::OFS_CTRL, 32'h200);
    EXT_CTRL <= 1'b1;
    wt(5);
    chk({30'h0, OPEN_P, OPEN_N}, 32'h2);
    EXT_CTRL <= 1'b0;
    wt(3);
    chk({31'h0, OPEN_P}, 32'h0);
    $display("t_ext done");
  endtask
  task automatic t_super;
    cut <= 1'b1;
    wt(4);
    rd(ocef_pkg::OFS_STATUS, 32'h2000);
    cut <= 1'b0;
    SELF_OK <= 1'b0;
    wt(2);
    chk({31'h0, INTERNAL_FAULT_ALARM}, 32'h1);
    SELF_OK <= 1'b1;
    $display("t_super done");
  endtask
  task automatic finish_test;
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge CLK_SYS)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      fails++;
      finish_test;
    end
  end
  initial
  begin
    wt(12);
    RST <= 1'b0;
    t_regs;
    t_phase;
    t_stages;
    t_modes;
    t_ext;
    t_super;
    finish_test;
  end
endmodule
